/* logic/dpi_pkg.sv */
package dpi_pkg;
	localparam logic [6:0] ADDR_LL = 7'h18;	// straps 00 -> 0011000
	localparam logic [6:0] ADDR_P1 = 7'h1A;	// pin1 high -> 0011010
	localparam logic [6:0] ADDR_P0 = 7'h4C;	// pin0 high -> 1001100
	localparam logic [6:0] ADDR_HH = 7'h4E;	// both high -> 1001110
	localparam logic [2:0] CMD_WIPER   = 3'h0;
	localparam logic [2:0] CMD_STORE   = 3'h1;
	localparam logic [2:0] CMD_PROTECT = 3'h2;
	localparam logic [2:0] CMD_NOP     = 3'h4;
	localparam logic [2:0] CMD_RESTORE = 3'h5;
	localparam logic [2:0] CMD_SAVE    = 3'h6;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	localparam logic [7:0] STORE_RESET = 8'h80;
	localparam int         SYNC_DEPTH  = 3;

	typedef struct packed {
		logic       valid;
		logic [2:0] cmd;
		logic [4:0] ptr;
		logic       has_data;
		logic [7:0] data;
		logic       is_instr;
	} dpi_evt_s;
endpackage

/* logic/dpi_sync.sv */
module dpi_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q,
	output logic              o_agree
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign o_q     = s3_r;
	assign o_agree = (s2_r == s3_r);
endmodule

/* logic/dpi_port.sv */
module dpi_port (
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RESET,
	input  wire logic       I_ADDR_STRAP_PIN0,
	input  wire logic       I_ADDR_STRAP_PIN1,
	input  wire logic       I_SCL,
	input  wire logic       I_SDA,
	output logic            O_SDA,
	output logic            O_SDA_OE,
	output logic [7:0]      O_WIPER_SETTING,
	output logic [7:0]      O_NONVOLATILE_STORE,
	output logic            O_WRITE_PROTECT,
	output logic            O_NV_READ_ACTIVE,
	output logic [6:0]      O_BUS_ADDRESS
);
	// the master's bus clock is oversampled by the core clock; no logic runs on it
	typedef enum {ST_IDLE, ST_ADDR, ST_INSTR, ST_WDATA, ST_RDATA, ST_SKIP} dpi_state_e;
	logic [1:0] pins_q;
	logic       pins_ok;
	logic [1:0] bus_q;
	logic       bus_ok;
	dpi_sync #(.W(2)) u_strap (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RESET),
		.i_d     ({I_ADDR_STRAP_PIN1, I_ADDR_STRAP_PIN0}),
		.o_q     (pins_q),
		.o_agree (pins_ok)
	);
	dpi_sync #(.W(2)) u_bus (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RESET),
		.i_d     ({I_SCL, I_SDA}),
		.o_q     (bus_q),
		.o_agree (bus_ok)
	);
	function automatic logic [6:0] strap_addr(input logic [1:0] p);
		unique case (p)
			2'h0: strap_addr = dpi_pkg::ADDR_LL;
			2'h2: strap_addr = dpi_pkg::ADDR_P1;
			2'h1: strap_addr = dpi_pkg::ADDR_P0;
			2'h3: strap_addr = dpi_pkg::ADDR_HH;
		endcase
	endfunction

	// strap capture: one shot once the zero-reset synchronisers have filled
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	logic       latched_r;
	logic       latched_nxt;
	logic [6:0] addr_r;
	logic [6:0] addr_nxt;
	wire logic  settled = (settle_r == 2'(dpi_pkg::SYNC_DEPTH));
	always_comb begin
		settle_nxt  = settled ? settle_r : settle_r + 2'h1;
		latched_nxt = latched_r;
		addr_nxt    = addr_r;
		if (!latched_r && settled && pins_ok) begin
			latched_nxt = 1'b1;
			addr_nxt    = strap_addr(pins_q);
		end
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			settle_r  <= 2'h0;
			latched_r <= 1'b0;
			addr_r    <= 7'h00;
		end else begin
			settle_r  <= settle_nxt;
			latched_r <= latched_nxt;
			addr_r    <= addr_nxt;
		end
	end

	// filtered bus levels: a change counts once stages two and three agree
	logic scl_r;
	logic scl_nxt;
	logic sda_r;
	logic sda_nxt;
	always_comb begin
		scl_nxt = (bus_ok && settled) ? bus_q[1] : scl_r;
		sda_nxt = (bus_ok && settled) ? bus_q[0] : sda_r;
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
		end
	end
	wire logic  scl_rise   = scl_nxt && !scl_r;
	wire logic  scl_fall   = !scl_nxt && scl_r;
	wire logic  start_cond = scl_r && scl_nxt && sda_r && !sda_nxt;
	wire logic  stop_cond  = scl_r && scl_nxt && !sda_r && sda_nxt;
	dpi_state_e st_r;
	dpi_state_e st_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic       ack_r;
	logic       ack_nxt;
	logic       drv_r;
	logic       drv_nxt;
	logic [2:0] cmd_r;
	logic [2:0] cmd_nxt;
	logic [4:0] ptr_r;
	logic [4:0] ptr_nxt;
	logic       nack_r;
	logic       nack_nxt;
	dpi_pkg::dpi_evt_s evt;
	logic [7:0] wiper_r;
	logic [7:0] wiper_nxt;
	logic [7:0] store_r;
	logic [7:0] store_nxt;
	logic       wp_r;
	logic       wp_nxt;
	logic       nvrd_r;
	logic       nvrd_nxt;
	logic [7:0] rd_byte;
	logic       done_byte;
	assign done_byte = scl_rise && (bit_r == 4'h7);
	always_comb begin
		rd_byte = 8'h00;
		if (cmd_r == dpi_pkg::CMD_WIPER)
			rd_byte = wiper_r;
		else if (cmd_r == dpi_pkg::CMD_STORE && ptr_r == 5'h00)
			rd_byte = store_r;
	end
	always_comb begin
		st_nxt   = st_r;
		sh_nxt   = sh_r;
		bit_nxt  = bit_r;
		ack_nxt  = ack_r;
		drv_nxt  = drv_r;
		cmd_nxt  = cmd_r;
		ptr_nxt  = ptr_r;
		nack_nxt = nack_r;
		evt      = '0;
		if (start_cond) begin
			// repeated start also lands here and keeps the pointer
			st_nxt  = ST_ADDR;
			bit_nxt = 4'h0;
			ack_nxt = 1'b0;
			drv_nxt = 1'b0;
		end else if (stop_cond) begin
			st_nxt  = ST_IDLE;
			drv_nxt = 1'b0;
		end else if (st_r != ST_IDLE && st_r != ST_SKIP) begin
			if (scl_rise && !ack_r && st_r != ST_RDATA) begin
				sh_nxt  = {sh_r[6:0], sda_r};
				bit_nxt = (bit_r == 4'h7) ? bit_r : bit_r + 4'h1;
			end
			if (scl_rise && ack_r && st_r == ST_RDATA)
				nack_nxt = sda_r;
			if (done_byte && !ack_r && st_r != ST_RDATA) begin
				ack_nxt = 1'b1;
				unique case (st_r)
					ST_ADDR: begin
						if (sh_r[6:0] != addr_r)
							st_nxt = ST_SKIP;
					end
					ST_INSTR: begin
						cmd_nxt      = sh_r[6:4];
						ptr_nxt      = {sh_r[3:0], sda_r};
						evt.valid    = 1'b1;
						evt.is_instr = 1'b1;
						evt.cmd      = sh_r[6:4];
					end
					default: begin
						evt.valid    = 1'b1;
						evt.has_data = 1'b1;
						evt.cmd      = cmd_r;
						evt.ptr      = ptr_r;
						evt.data     = {sh_r[6:0], sda_r};
					end
				endcase
			end
			if (st_r == ST_RDATA && scl_rise && !ack_r && bit_r != 4'h7)
				bit_nxt = bit_r + 4'h1;
			if (scl_fall) begin
				if (ack_r && bit_r == 4'h8) begin
					// ack slot just ended: pick next phase
					ack_nxt = 1'b0;
					bit_nxt = 4'h0;
					drv_nxt = 1'b0;
					unique case (st_r)
						ST_ADDR: begin
							st_nxt = sh_r[0] ? ST_RDATA : ST_INSTR;
							if (sh_r[0]) begin
								drv_nxt = !rd_byte[7];
								sh_nxt  = {rd_byte[6:0], 1'b0};
							end
						end
						ST_INSTR: st_nxt = ST_WDATA;
						ST_WDATA: st_nxt = ST_WDATA;
						default: begin
							st_nxt = nack_r ? ST_SKIP : ST_RDATA;
							if (!nack_r) begin
								drv_nxt = !rd_byte[7];
								sh_nxt  = {rd_byte[6:0], 1'b0};
							end
						end
					endcase
				end else if (ack_r && bit_r == 4'h7 && st_r == ST_RDATA) begin
					drv_nxt = 1'b0;	// release for master ack
					bit_nxt = 4'h8;
				end else if (ack_r) begin
					drv_nxt = (st_r != ST_RDATA);
					bit_nxt = 4'h8;
				end else if (st_r == ST_RDATA) begin
					drv_nxt = !sh_r[7];
					sh_nxt  = {sh_r[6:0], 1'b0};
				end
			end
			if (st_r == ST_RDATA && scl_rise && bit_r == 4'h7 && !ack_r)
				ack_nxt = 1'b1;
		end
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			st_r   <= ST_IDLE;
			sh_r   <= 8'h00;
			bit_r  <= 4'h0;
			ack_r  <= 1'b0;
			drv_r  <= 1'b0;
			cmd_r  <= dpi_pkg::CMD_WIPER;
			ptr_r  <= 5'h00;
			nack_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			sh_r   <= sh_nxt;
			bit_r  <= bit_nxt;
			ack_r  <= ack_nxt;
			drv_r  <= drv_nxt;
			cmd_r  <= cmd_nxt;
			ptr_r  <= ptr_nxt;
			nack_r <= nack_nxt;
		end
	end

	// command execution; 011 and 111 fall through untouched
	always_comb begin
		wiper_nxt = wiper_r;
		store_nxt = store_r;
		wp_nxt    = wp_r;
		nvrd_nxt  = nvrd_r;
		if (evt.valid && evt.is_instr) begin
			unique case (evt.cmd)
				dpi_pkg::CMD_RESTORE: begin
					wiper_nxt = store_r;
					nvrd_nxt  = 1'b1;
				end
				dpi_pkg::CMD_SAVE: if (!wp_r) store_nxt = wiper_r;
				dpi_pkg::CMD_NOP: nvrd_nxt = 1'b0;
				default: ;
			endcase
		end else if (evt.valid && evt.has_data) begin
			unique case (evt.cmd)
				dpi_pkg::CMD_WIPER: if (!wp_r) wiper_nxt = evt.data;
				dpi_pkg::CMD_STORE: begin
					if (!wp_r && evt.ptr == 5'h00)
						store_nxt = evt.data;
				end
				dpi_pkg::CMD_PROTECT: wp_nxt = evt.data[0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			wiper_r <= dpi_pkg::WIPER_RESET;
			store_r <= dpi_pkg::STORE_RESET;
			wp_r    <= 1'b0;
			nvrd_r  <= 1'b0;
		end else begin
			wiper_r <= wiper_nxt;
			store_r <= store_nxt;
			wp_r    <= wp_nxt;
			nvrd_r  <= nvrd_nxt;
		end
	end
	assign O_SDA               = 1'b0;
	assign O_SDA_OE            = drv_r;
	assign O_WIPER_SETTING     = wiper_r;
	assign O_NONVOLATILE_STORE = store_r;
	assign O_WRITE_PROTECT     = wp_r;
	assign O_NV_READ_ACTIVE    = nvrd_r;
	assign O_BUS_ADDRESS       = addr_r;

	property p_wp_reset;
		@(posedge I_REF_CLK) $fell(I_RESET) |-> !wp_r;
	endproperty
	a_wp_reset: assert property (p_wp_reset) else $error("protect not clear");
	property p_addr_fixed;
		@(posedge I_REF_CLK) disable iff (I_RESET) latched_r |=> $stable(addr_r);
	endproperty
	a_addr_fixed: assert property (p_addr_fixed) else $error("address moved");
	property p_addr_map;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			$rose(latched_r) |-> addr_r == strap_addr($past(pins_q));
	endproperty
	a_addr_map: assert property (p_addr_map) else $error("bad strap decode");
	property p_restore;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			evt.valid && evt.is_instr && evt.cmd == dpi_pkg::CMD_RESTORE
			|=> wiper_r == $past(store_r) && nvrd_r;
	endproperty
	a_restore: assert property (p_restore) else $error("restore failed");
	property p_nop;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			evt.valid && evt.is_instr && evt.cmd == dpi_pkg::CMD_NOP |=> !nvrd_r;
	endproperty
	a_nop: assert property (p_nop) else $error("nop left read power");
	property p_protect_wiper;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			wp_r && !(evt.valid && evt.is_instr && evt.cmd == dpi_pkg::CMD_RESTORE)
			|=> $stable(wiper_r);
	endproperty
	a_protect_wiper: assert property (p_protect_wiper) else $error("wiper changed");
	property p_wiper_load;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			evt.valid && evt.has_data && evt.cmd == dpi_pkg::CMD_WIPER && !wp_r
			|=> wiper_r == $past(evt.data);
	endproperty
	a_wiper_load: assert property (p_wiper_load) else $error("wiper not loaded");
	property p_protect_set;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			evt.valid && evt.has_data && evt.cmd == dpi_pkg::CMD_PROTECT
			|=> wp_r == $past(evt.data[0]);
	endproperty
	a_protect_set: assert property (p_protect_set) else $error("protect flag wrong");
	property p_skip_quiet;
		@(posedge I_REF_CLK) disable iff (I_RESET) st_r == ST_SKIP |-> !drv_r;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("drove when unaddressed");
	property p_fall_only;
		@(posedge I_REF_CLK) disable iff (I_RESET)
			st_r == ST_RDATA && $changed(drv_r) |-> $past(scl_fall) || $past(start_cond);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("read bit moved off fall");
endmodule

/* bench/dpi_master.sv */
module dpi_master #(
	parameter int Q = 25
) (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus clock rests high between frames and only toggles inside one
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end

	task automatic qwait();
		repeat (Q) @(posedge i_clk);
	endtask

	// also serves as repeated start when entered with the clock low
	task automatic start();
		if (o_scl === 1'b0) begin
			qwait();
			o_sda_pull = 1'b0;
			qwait();
			o_scl = 1'b1;
		end
		qwait();
		o_sda_pull = 1'b1;
		qwait();
		o_scl = 1'b0;
	endtask

	task automatic stop();
		qwait();
		o_sda_pull = 1'b1;
		qwait();
		o_scl = 1'b1;
		qwait();
		o_sda_pull = 1'b0;
		qwait();
		qwait();
	endtask

	// early and late samples of the high phase differ if data moves while clock is high
	task automatic xbit(input logic b, output logic s_early, output logic s_late);
		qwait();
		o_sda_pull = ~b;
		qwait();
		o_scl = 1'b1;
		repeat (2) @(posedge i_clk);
		s_early = i_sda;
		repeat (2 * Q - 3) @(posedge i_clk);
		s_late = i_sda;
		@(posedge i_clk);
		o_scl = 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic e;
		logic l;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], e, l);
		end
		xbit(1'b1, e, l);
		ack = ~e;
	endtask

	task automatic rbyte(input logic nack, output logic [7:0] d, output logic [7:0] d_late);
		logic e;
		logic l;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, e, l);
			d[i] = e;
			d_late[i] = l;
		end
		xbit(nack, e, l);
	endtask
endmodule

/* bench/dpi_port_tb.sv */
module dpi_port_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] I_WIP = {dpi_pkg::CMD_WIPER, 5'h00};
	localparam logic [7:0] I_STO = {dpi_pkg::CMD_STORE, 5'h00};
	localparam logic [7:0] I_PRO = {dpi_pkg::CMD_PROTECT, 5'h00};

	logic       ref_clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       reset = 1'b1;
	logic       strap0 = 1'b1;
	logic       strap1 = 1'b0;
	logic       scl;
	logic       pull;
	logic       sda_out;
	logic       sda_oe;
	wire logic  sda_wire;
	logic [7:0] wiper;
	logic [7:0] store;
	logic       protect;
	logic       nv_act;
	logic [6:0] bus_addr;
	logic [6:0] own;
	int         n_mismatch = 0;
	int         checked = 0;

	always #20 ref_clk = ~ref_clk;
	always #3 link_clk = ~link_clk;
	// pulled-up wire, low while either party pulls
	assign sda_wire = ~pull & (~sda_oe | sda_out);

	dpi_port dut (.I_REF_CLK(ref_clk), .I_RESET(reset), .I_ADDR_STRAP_PIN0(strap0),
		.I_ADDR_STRAP_PIN1(strap1), .I_SCL(scl), .I_SDA(sda_wire), .O_SDA(sda_out),
		.O_SDA_OE(sda_oe), .O_WIPER_SETTING(wiper), .O_NONVOLATILE_STORE(store),
		.O_WRITE_PROTECT(protect), .O_NV_READ_ACTIVE(nv_act), .O_BUS_ADDRESS(bus_addr));
	dpi_master m (.i_clk(link_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_pull(pull));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// bytes are acknowledged only when the frame is addressed to this device
	task automatic wr(input logic [6:0] a, input logic [7:0] ins, input int n,
			input logic [7:0] d0, input logic [7:0] d1);
		logic       ack;
		logic [7:0] ea;
		ea = {7'h00, a == own};
		m.start();
		m.wbyte({a, 1'b0}, ack);
		check("addr ack", {7'h00, ack}, ea);
		m.wbyte(ins, ack);
		check("instr ack", {7'h00, ack}, ea);
		for (int i = 0; i < n; i++) begin
			m.wbyte(i == 0 ? d0 : d1, ack);
			check("data ack", {7'h00, ack}, ea);
		end
		m.stop();
	endtask

	task automatic rd(input logic dummy, input logic [7:0] ins, output logic [7:0] d);
		logic       ack;
		logic [7:0] late;
		m.start();
		if (dummy) begin
			m.wbyte({own, 1'b0}, ack);
			m.wbyte(ins, ack);
			m.start();
		end
		m.wbyte({own, 1'b1}, ack);
		check("read ack", {7'h00, ack}, 8'h01);
		m.rbyte(1'b1, d, late);
		check("read hold", late, d);
		m.stop();
	endtask

	task automatic regs(input logic [7:0] w, input logic [7:0] s, input logic p, input logic nv);
		repeat (4) @(negedge ref_clk);
		check("wiper", wiper, w);
		check("store", store, s);
		check("protect", {7'h00, protect}, {7'h00, p});
		check("nv read", {7'h00, nv_act}, {7'h00, nv});
	endtask

	task automatic do_reset();
		@(negedge ref_clk);
		reset = 1'b1;
		repeat (8) @(negedge ref_clk);
		reset = 1'b0;
		repeat (12) @(negedge ref_clk);
	endtask

	initial begin
		logic [7:0] d;
		logic [6:0] tbl [4];
		tbl = '{dpi_pkg::ADDR_LL, dpi_pkg::ADDR_P1, dpi_pkg::ADDR_P0, dpi_pkg::ADDR_HH};
		own = dpi_pkg::ADDR_P0;
		do_reset();
		check("address", {1'b0, bus_addr}, {1'b0, own});
		regs(dpi_pkg::WIPER_RESET, dpi_pkg::STORE_RESET, 1'b0, 1'b0);
		strap0 = 1'b0;
		strap1 = 1'b1;
		wr(own, I_WIP, 2, 8'h11, 8'h22);
		regs(8'h22, dpi_pkg::STORE_RESET, 1'b0, 1'b0);
		check("address", {1'b0, bus_addr}, {1'b0, own});
		rd(1'b1, I_WIP, d);
		check("wiper read", d, 8'h22);
		wr(own, I_STO, 1, 8'h5A, 8'h00);
		rd(1'b0, I_WIP, d);
		check("store read", d, 8'h5A);
		rd(1'b1, I_STO, d);
		check("store read", d, 8'h5A);
		wr(own, {dpi_pkg::CMD_RESTORE, 5'h00}, 0, 8'h00, 8'h00);
		regs(8'h5A, 8'h5A, 1'b0, 1'b1);
		wr(own, {dpi_pkg::CMD_NOP, 5'h00}, 0, 8'h00, 8'h00);
		regs(8'h5A, 8'h5A, 1'b0, 1'b0);
		wr(own, I_WIP, 1, 8'h77, 8'h00);
		wr(own, {dpi_pkg::CMD_SAVE, 5'h00}, 0, 8'h00, 8'h00);
		regs(8'h77, 8'h77, 1'b0, 1'b0);
		wr(own, I_PRO, 1, 8'h01, 8'h00);
		wr(own, I_WIP, 1, 8'h99, 8'h00);
		wr(own, I_STO, 1, 8'h99, 8'h00);
		regs(8'h77, 8'h77, 1'b1, 1'b0);
		wr(own, I_PRO, 1, 8'h00, 8'h00);
		regs(8'h77, 8'h77, 1'b0, 1'b0);
		wr(own, 8'h60, 1, 8'h12, 8'h00);
		wr(own, 8'hE0, 1, 8'h12, 8'h00);
		regs(8'h77, 8'h77, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(tbl[i], I_WIP, 1, 8'(16 + i), 8'h00);
		end
		regs(8'h12, 8'h77, 1'b0, 1'b0);
		wr(own, I_PRO, 1, 8'h01, 8'h00);
		do_reset();
		own = dpi_pkg::ADDR_P1;
		check("address", {1'b0, bus_addr}, {1'b0, own});
		regs(dpi_pkg::WIPER_RESET, dpi_pkg::STORE_RESET, 1'b0, 1'b0);
		wr(own, I_WIP, 1, 8'hA5, 8'h00);
		regs(8'hA5, dpi_pkg::STORE_RESET, 1'b0, 1'b0);
		final_report();
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end
endmodule
